//--- logic/cp_glue_pkg.sv
/*
  Shared types and constants for the coprocessor exception busy latch glue.
  Assumes one clock (mclk) and one active-high asynchronous reset.
*/
package cp_glue_pkg;

  // ----------------------------------------------------------------
  // io port decode
  // ----------------------------------------------------------------
  localparam logic [15:0] CLEAR_PORT_ADDR = 16'h00F0; // handler clear port

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic        LATCH_RESET     = 1'h0;     // latch empty
  localparam logic        SYNC_RESET_HIGH = 1'h1;     // idle level, low-true

  // ----------------------------------------------------------------
  // state encoding, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,  // no pending exception
    ST_WAITCP  = 3'h2,  // error seen, coprocessor still busy
    ST_REQ     = 3'h4   // coprocessor idle, operand request re-driven
  } glue_state_e;

  // coprocessor pin bundle, all active low except request
  typedef struct packed {
    logic busyN;        // coprocessor busy, low true
    logic errorN;       // coprocessor error, low true
    logic operandReq;   // operand_transfer_request from coprocessor
  } cp_pins_s;

  // host side outputs
  typedef struct packed {
    logic hostBusyN;       // busy into host, low true
    logic hostOperandReq;  // operand request into host
    logic numericIrqLine;  // interrupt request line 13
    logic hostErrorN;      // host error input, held inactive
    logic statusEnableIn;  // coprocessor select, held high
  } host_pins_s;

  // host io write strobe
  typedef struct packed {
    logic        ioWrite;  // one-cycle io write pulse
    logic [15:0] ioAddr;   // io port address
  } io_wr_s;

endpackage : cp_glue_pkg

//--- logic/pin_sync.sv
/*
  Two-flop synchroniser bank for the coprocessor pins.
  Assumes pins are asynchronous to mclk; idle level is set by parameter.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int         W    = 3,          // number of pins
  parameter logic [2:0] INIT = 3'h7        // reset level of each pin
) (
  input  wire logic         mclk,          // system clock
  input  wire logic         rst,           // async reset, high
  input  wire logic [W-1:0] pinIn,         // raw pins
  output var  logic [W-1:0] pinSync        // synchronised pins
);
  import cp_glue_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta;  // first stage, read only by second
    logic [W-1:0] sync;  // second stage
  } sync_s;

  sync_s sync_r;   // registered state
  sync_s sync_nxt; // next state

  // shift pins through both stages
  always_comb begin
    sync_nxt      = sync_r;
    sync_nxt.meta = pinIn;
    sync_nxt.sync = sync_r.meta;
  end

  // register with constant reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_r <= {INIT[W-1:0], INIT[W-1:0]};
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign pinSync = sync_r.sync;

endmodule // pin_sync
`default_nettype wire

//--- logic/coprocessor_exception_busy_latch.sv
/*
  Compatible exception glue between a host processor and its numeric
  coprocessor: error raises an interrupt, a latch extends busy and the
  operand request is re-driven until the handler writes the clear port.
  Assumes coprocessor pins are asynchronous, host io strobes on mclk, and
  one shared reset for host, coprocessor and this block.
*/
//
// Summary of operation
// - coprocessor drops request on exception
// - coprocessor ignores dummy transfer cycles
// - standard connection uses dedicated error line; this glue holds hostErrorN high and raises numericIrqLine instead
// - legacy interrupt opcodes act as no-ops
//
`timescale 1ns/1ps
`default_nettype none
module coprocessor_exception_busy_latch (
  input  wire logic                    mclk,     // system clock
  input  wire logic                    rst,      // shared reset, high
  input  wire cp_glue_pkg::cp_pins_s   cpPins,   // raw coprocessor pins
  input  wire cp_glue_pkg::io_wr_s     ioWr,     // host io write
  output var  cp_glue_pkg::host_pins_s hostPins  // signals to host side
);
  import cp_glue_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [2:0] pinsSync;   // busyN, errorN, operandReq
  logic       cpBusyN;    // synchronised busy, low true
  logic       cpErrorN;   // synchronised error, low true
  logic       cpReq;      // synchronised operand request

  pin_sync #(
    .W    (3),
    .INIT (3'h6)
  ) u_pin_sync (
    .mclk    (mclk),
    .rst     (rst),
    .pinIn   ({cpPins.busyN, cpPins.errorN, cpPins.operandReq}),
    .pinSync (pinsSync)
  );

  assign cpBusyN  = pinsSync[2];
  assign cpErrorN = pinsSync[1];
  assign cpReq    = pinsSync[0];

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // true for an io write to the handler clear port; every other io
  // cycle, dummy operand transfers included, passes unseen
  function automatic logic is_clear_write(input io_wr_s w);
    return w.ioWrite && (w.ioAddr == CLEAR_PORT_ADDR);
  endfunction

  logic clearHit;  // handler clear this cycle
  assign clearHit = is_clear_write(ioWr);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    glue_state_e state;     // exception sequence
    logic        errPrevN;  // last error level, edge detect
    logic        busyLatch; // captured busy on error edge
    logic        hostBusyN; // registered busy to host
    logic        hostReq;   // registered request to host
    logic        irq;       // registered interrupt line
  } glue_s;

  glue_s st_r;   // registered state
  glue_s st_nxt; // next state

  // edge detect runs on the synchronised level; errPrevN resets to the
  // idle (high) level so a quiet pin gives no false edge after reset
  logic errFall;  // error assertion edge
  assign errFall = st_r.errPrevN && !cpErrorN;

  // next-state logic
  always_comb begin
    // hold everything; no opcode reaches this block, so legacy
    // interrupt opcodes cannot move it
    st_nxt          = st_r;
    st_nxt.errPrevN = cpErrorN;
    // latch busy on the error edge; set beats a same-cycle clear
    if (errFall) begin
      st_nxt.busyLatch = !cpBusyN;
    end else if (clearHit) begin
      st_nxt.busyLatch = 1'h0;
    end
    // sequence for request re-drive
    case (st_r.state)
      ST_IDLE: begin
        if (errFall) begin
          st_nxt.state = ST_WAITCP;
        end
      end
      ST_WAITCP: begin
        if (clearHit) begin
          st_nxt.state = ST_IDLE;
        end else if (cpBusyN) begin
          st_nxt.state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (clearHit) begin
          st_nxt.state = ST_IDLE;
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase
    // busy to host: coprocessor busy, latch or any state other than ST_IDLE, active low
    st_nxt.hostBusyN = !((!cpBusyN) || st_nxt.busyLatch ||
                         (st_nxt.state != ST_IDLE));
    // request to host: own request, which the coprocessor drops on a
    // fault, or the re-drive after busy drops
    st_nxt.hostReq = cpReq || (st_nxt.state == ST_REQ);
    // interrupt follows the error pin, active high
    st_nxt.irq = !cpErrorN;
  end

  // register with constant reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r.state     <= ST_IDLE;
      st_r.errPrevN  <= SYNC_RESET_HIGH;
      st_r.busyLatch <= LATCH_RESET;
      st_r.hostBusyN <= SYNC_RESET_HIGH;
      st_r.hostReq   <= 1'h0;
      st_r.irq       <= 1'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    hostPins.hostBusyN      = st_r.hostBusyN;
    hostPins.hostOperandReq = st_r.hostReq;
    hostPins.numericIrqLine = st_r.irq;
    // the dedicated error line stays unused, errors go out as an
    // interrupt instead
    hostPins.hostErrorN     = 1'h1;
    hostPins.statusEnableIn = 1'h1;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // all checks run on mclk and sleep while reset is high
  chk_err_to_irq: assert property (@(posedge mclk)
    disable iff (rst)
    $fell(cpErrorN) |=> hostPins.numericIrqLine)
    else $error("irq did not follow error");

  chk_irq_release: assert property (@(posedge mclk)
    disable iff (rst)
    $rose(cpErrorN) |=> !hostPins.numericIrqLine)
    else $error("irq stayed after error released");

  chk_busy_latch_set: assert property (@(posedge mclk)
    disable iff (rst)
    (errFall && !cpBusyN) |=> st_r.busyLatch)
    else $error("busy not latched on error edge");

  chk_set_wins: assert property (@(posedge mclk)
    disable iff (rst)
    (errFall && clearHit && !cpBusyN) |=> st_r.busyLatch)
    else $error("clear beat a same-cycle error edge");

  chk_busy_follow: assert property (@(posedge mclk)
    disable iff (rst)
    !cpBusyN |=> !hostPins.hostBusyN)
    else $error("host busy missed coprocessor busy");

  chk_busy_extend: assert property (@(posedge mclk)
    disable iff (rst)
    st_r.busyLatch |-> !hostPins.hostBusyN)
    else $error("host busy released with latch set");

  chk_busy_holds: assert property (@(posedge mclk)
    disable iff (rst)
    (st_r.state == ST_REQ && !clearHit) |=> !hostPins.hostBusyN)
    else $error("host busy dropped before clear");

  chk_clear_port: assert property (@(posedge mclk)
    disable iff (rst)
    (clearHit && !errFall) |=> (!st_r.busyLatch && st_r.state == ST_IDLE))
    else $error("clear port write did not clear");

  chk_clear_release: assert property (@(posedge mclk)
    disable iff (rst)
    (clearHit && !errFall && cpBusyN) |=> hostPins.hostBusyN)
    else $error("host busy held after clear");

  chk_req_after_busy: assert property (@(posedge mclk)
    disable iff (rst)
    (st_r.state == ST_WAITCP && cpBusyN && !clearHit) |=>
      hostPins.hostOperandReq)
    else $error("request not re-driven after busy");

  chk_no_early_req: assert property (@(posedge mclk)
    disable iff (rst)
    (st_r.state == ST_WAITCP && !cpBusyN && !cpReq) |=>
      !hostPins.hostOperandReq)
    else $error("request re-driven while busy");

  chk_req_follow: assert property (@(posedge mclk)
    disable iff (rst)
    (st_r.state == ST_IDLE && !errFall && cpReq) |=> hostPins.hostOperandReq)
    else $error("request not passed to host");

  chk_tied_pins: assert property (@(posedge mclk)
    disable iff (rst)
    hostPins.hostErrorN && hostPins.statusEnableIn)
    else $error("tied pins not held high");

endmodule // coprocessor_exception_busy_latch
`default_nettype wire

//--- tb/cp_model.sv
/*
  Behavioural numeric coprocessor pins for the glue bench.
  Assumes commands from the bench change just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module cp_model (
  input  wire logic                  mclk,     // system clock
  input  wire logic                  rst,      // shared reset, high
  input  wire logic                  runOp,    // instruction in progress
  input  wire logic                  fault,    // exception raised
  input  wire logic                  wantXfer, // operand transfer wanted
  output var  cp_glue_pkg::cp_pins_s pins      // pins toward the glue
);
  import cp_glue_pkg::*;
  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // pins follow the commands one edge later
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pins <= cp_pins_s'(3'h6); // idle pins on shared reset
    end else begin
      pins.busyN      <= ~runOp;
      pins.errorN     <= ~fault; // own error line
      // request dropped once fault shows
      pins.operandReq <= wantXfer & ~fault & runOp;
    end
  end
  // no input for dummy cycles: they cannot disturb it
endmodule // cp_model
`default_nettype wire

//--- tb/coprocessor_exception_busy_latch_tb_top.sv
/*
  Self-checking bench for the exception busy latch glue.
  Assumes the design package and the cp_model partner are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module coprocessor_exception_busy_latch_tb_top;
  import cp_glue_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic       mclk;     // bench clock
  logic       rst;      // shared reset
  logic       runOp;    // partner busy command
  logic       fault;    // partner error command
  logic       wantXfer; // partner request command
  cp_pins_s   cpPins;   // partner pins
  io_wr_s     ioWr;     // host io write
  host_pins_s hostPins; // glue outputs
  int         failures; // mismatch count
  int         checks;   // comparison count
  int         cycles;   // timeout counter

  always #2 mclk = ~mclk;

  cp_model u_cp (.mclk(mclk), .rst(rst), .runOp(runOp), .fault(fault),
                 .wantXfer(wantXfer), .pins(cpPins));
  coprocessor_exception_busy_latch u_dut (.mclk(mclk), .rst(rst),
    .cpPins(cpPins), .ioWr(ioWr), .hostPins(hostPins));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // compare outputs; error input and select always inactive/high
  task automatic expect_pins(input logic b, input logic q, input logic i);
    host_pins_s exp;
    exp = host_pins_s'({b, q, i, 2'h3});
    checks++;
    if (hostPins !== exp) begin
      failures++;
      $display("[FAIL] %0t pins %b want %b", $time, hostPins, exp);
    end
  endtask
  // let synchroniser and output register settle
  task automatic settle;
    repeat (6) @(posedge mclk);
    #1;
  endtask
  // one-cycle io write strobe
  task automatic io_write(input logic [15:0] a);
    ioWr = '{ioWrite: 1'h1, ioAddr: a};
    @(posedge mclk);
    #1;
    ioWr.ioWrite = 1'h0;
    settle();
  endtask
  task automatic complete_run;
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // plain busy and request pass through
  task automatic t_busy;
    runOp = 1'h1;
    settle();
    expect_pins(1'h0, 1'h0, 1'h0);
    wantXfer = 1'h1;
    settle();
    expect_pins(1'h0, 1'h1, 1'h0);
    wantXfer = 1'h0;
    runOp = 1'h0;
    settle();
    expect_pins(1'h1, 1'h0, 1'h0);
  endtask
  // fault during a store, then handler clear
  task automatic t_error;
    runOp = 1'h1;
    wantXfer = 1'h1;
    settle();
    fault = 1'h1;
    settle();
    expect_pins(1'h0, 1'h0, 1'h1);
    io_write(16'h00F1);
    expect_pins(1'h0, 1'h0, 1'h1);
    runOp = 1'h0;
    wantXfer = 1'h0;
    settle();
    expect_pins(1'h0, 1'h1, 1'h1);
    fault = 1'h0;
    settle();
    expect_pins(1'h0, 1'h1, 1'h0);
    io_write(CLEAR_PORT_ADDR);
    expect_pins(1'h1, 1'h0, 1'h0);
    runOp = 1'h1;
    settle();
    runOp = 1'h0;
    settle();
    expect_pins(1'h1, 1'h0, 1'h0);
  endtask
  // error edge and clear write meet in one cycle: the set wins
  task automatic t_samecycle;
    runOp = 1'h1;
    settle();
    fault = 1'h1;
    repeat (3) @(posedge mclk);
    #1;
    io_write(CLEAR_PORT_ADDR);
    expect_pins(1'h0, 1'h0, 1'h1);
    runOp = 1'h0;
    fault = 1'h0;
    settle();
    expect_pins(1'h0, 1'h1, 1'h0);
    io_write(CLEAR_PORT_ADDR);
    expect_pins(1'h1, 1'h0, 1'h0);
  endtask
  // reset in mid-exception empties the latch
  task automatic t_midreset;
    runOp = 1'h1;
    fault = 1'h1;
    settle();
    rst = 1'h1;
    @(posedge mclk);
    #1;
    expect_pins(1'h1, 1'h0, 1'h0);
    runOp = 1'h0;
    fault = 1'h0;
    rst = 1'h0;
    settle();
    expect_pins(1'h1, 1'h0, 1'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence and timeout
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    rst = 1'h1;
    runOp = 1'h0;
    fault = 1'h0;
    wantXfer = 1'h0;
    ioWr = '{ioWrite: 1'h0, ioAddr: 16'h0000};
    failures = 0;
    checks = 0;
    cycles = 0;
    repeat (16) @(posedge mclk);
    #1;
    expect_pins(1'h1, 1'h0, 1'h0);
    rst = 1'h0;
    settle();
    expect_pins(1'h1, 1'h0, 1'h0);
    t_busy();
    t_error();
    t_samecycle();
    t_midreset();
    complete_run();
  end

  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      complete_run();
    end
  end
endmodule // coprocessor_exception_busy_latch_tb_top
`default_nettype wire
